// ==== verilog/itm_pkg.sv ====
// Constants, register map and types of the inverter thermal and modulation controller.
package itm_pkg;
  localparam int CLK_MHZ = 200;
  localparam int SAMPLE_US = 125;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  localparam int FAN_MIN_ON_S = 60;
  localparam int FAN_MIN_SMP = FAN_MIN_ON_S * 1000000 / SAMPLE_US;
  localparam int SW_STEP_MS = 10;
  localparam int SW_STEP_SMP = SW_STEP_MS * 1000 / SAMPLE_US;
  localparam logic [15:0] PCT_ONE = 16'h2710;
  localparam logic signed [15:0] T_HYST = 16'sh0032;
  localparam logic [4:0] SW_STEP_KHZ = 5'h02;
  localparam logic signed [15:0] SW_MAX_RST_1XX = 16'sh0002;
  localparam int FRAC = 8;
  localparam int NREG = 14;
  localparam logic [3:0] A_MOD_REF = 4'h0;
  localparam logic [3:0] A_MOD_TI = 4'h1;
  localparam logic [3:0] A_MOD_SEL = 4'h2;
  localparam logic [3:0] A_DEV_LIM = 4'h3;
  localparam logic [3:0] A_IMR_LO = 4'h4;
  localparam logic [3:0] A_IMR_RATED = 4'h5;
  localparam logic [3:0] A_REF_FLUX = 4'h6;
  localparam logic [3:0] A_SW_MAX = 4'h7;
  localparam logic [3:0] A_SW_MIN = 4'h8;
  localparam logic [3:0] A_T_RED = 4'h9;
  localparam logic [3:0] A_T_OFF = 4'hA;
  localparam logic [3:0] A_FAN_TON = 4'hB;
  localparam logic [3:0] A_I_OL = 4'hC;
  localparam logic [3:0] A_CTRL = 4'hD;
  localparam logic [3:0] A_STATUS = 4'hE;
  localparam logic [3:0] A_FLUX = 4'hF;
  localparam logic signed [15:0] REG_RST [NREG] = '{16'sh27D8, 16'sh0064, 16'sh0000, 16'sh03E8,
    16'sh0064, 16'sh2710, 16'sh2710, 16'sh0004, 16'sh0002, 16'shFFD8, 16'sh0320, 16'sh0000,
    16'sh03E8, 16'sh0000};
  localparam logic signed [15:0] REG_MIN [NREG] = '{16'sh012C, 16'sh0000, 16'sh0000, 16'sh0000,
    16'sh0064, 16'sh0000, 16'sh0001, 16'sh0002, 16'sh0002, 16'shFF06, 16'sh0000, 16'sh0000,
    16'sh0000, 16'sh0000};
  localparam logic signed [15:0] REG_MAX [NREG] = '{16'sh2904, 16'sh2710, 16'sh0001, 16'sh2710,
    16'sh7FFF, 16'sh7FFF, 16'sh7530, 16'sh0010, 16'sh0010, 16'sh0000, 16'sh7FFF, 16'sh0258,
    16'sh7FFF, 16'sh0001};

  typedef struct packed {
    logic [15:0] usq;
    logic [15:0] vabs;
    logic [15:0] udc;
    logic [15:0] iout;
    logic signed [15:0] t_hs;
  } itm_meas_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_MOD = 4'h2,
    ST_INT = 4'h4,
    ST_UPD = 4'h8
  } itm_state_e;
endpackage : itm_pkg

// ==== verilog/itm_div.sv ====
// Serial unsigned divider, 32-bit numerator by 16-bit denominator.
`timescale 1ns/1ps
`default_nettype none
module itm_div (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [31:0] num_i,
  input wire logic [15:0] den_i,
  output logic done_o,
  output logic [31:0] quo_o
);
  logic [31:0] quo_q;
  logic [15:0] rem_q;
  logic [5:0] cnt_q;
  logic busy_q;
  logic done_q;
  wire [16:0] rem_sh = {rem_q, quo_q[31]};
  wire fit = rem_sh >= {1'b0, den_i};
  wire [16:0] rem_sub = rem_sh - {1'b0, den_i};

  // A zero denominator saturates the quotient at once.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      quo_q <= 32'h0;
      rem_q <= 16'h0;
      cnt_q <= 6'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start_i) begin
        rem_q <= 16'h0;
        cnt_q <= 6'h20;
        busy_q <= (den_i != 16'h0);
        done_q <= (den_i == 16'h0);
        quo_q <= (den_i == 16'h0) ? 32'hFFFFFFFF : num_i;
      end else if (busy_q) begin
        rem_q <= fit ? rem_sub[15:0] : rem_sh[15:0];
        quo_q <= {quo_q[30:0], fit};
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign done_o = done_q;
  assign quo_o = quo_q;
endmodule : itm_div
`default_nettype wire

// ==== verilog/itm_ctrl.sv ====
// Modulation controller, switching frequency adaptation and fan control of the inverter.
//
// Functional notes
// - Modulation above reference lowers flux reference.
// - Controller is pure integral, settable integral time.
// - Selector picks torque voltage or magnitude.
// - Flux output and integrator clamped between limits.
// - Control deviation clamped to plus/minus limit.
// - Maximum switching frequency 2 to 16 kHz.
// - Frequency kept between configured minimum and maximum.
// - Minimum at or above maximum disables reduction.
// - Heat-sink above reduction limit lowers frequency.
// - Five degrees below limit raises frequency stepwise.
// - Current above 87.5 percent overload lowers frequency.
// - Current below next step reference raises frequency.
// - Mains and hot heat-sink turn fan on.
// - Powered, enabled and started turns fan on.
// - Fan off on cooling or disable, after minimum.
// - Fan minimum on-time is one minute.
// - External fan output with same minimum on-time.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module itm_ctrl #(
  parameter int SAMPLE_CYC = itm_pkg::SAMPLE_CYC,
  parameter int FAN_MIN_SMP = itm_pkg::FAN_MIN_SMP,
  parameter bit CFG_1XX = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire itm_pkg::itm_meas_s meas_i,
  input wire logic output_stage_enable_input_i,
  input wire logic mains_ok_i,
  input wire logic ctrl_enable_i,
  input wire logic start_cw_i,
  input wire logic start_ccw_i,
  output logic pwm_enable_o,
  output logic [15:0] flux_ref_o,
  output logic [4:0] sw_freq_khz_o,
  output logic fan_int_o,
  output logic fan_ext_o
);
  // Pin synchronisers.
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
    end else begin
      pin_s1_q <= {output_stage_enable_input_i, mains_ok_i, ctrl_enable_i, start_cw_i, start_ccw_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire stage_en = pin_s2_q[4];
  wire mains = pin_s2_q[3];
  wire ctrl_en = pin_s2_q[2];
  wire started = pin_s2_q[1] | pin_s2_q[0];

  // Configuration registers with write clamping to their ranges.
  logic signed [15:0] cfg_q [itm_pkg::NREG];
  wire addr_ok = reg_addr_i < 4'(itm_pkg::NREG);
  wire [3:0] idx = addr_ok ? reg_addr_i : 4'h0;
  wire signed [15:0] wr_min = itm_pkg::REG_MIN[idx];
  wire signed [15:0] wr_max = itm_pkg::REG_MAX[idx];
  wire signed [15:0] wdata_s = $signed(reg_wdata_i);
  wire signed [15:0] wr_val = (wdata_s < wr_min) ? wr_min : (wdata_s > wr_max) ? wr_max : wdata_s;
  genvar g;
  generate
    for (g = 0; g < itm_pkg::NREG; g++) begin : g_reg
      localparam logic signed [15:0] RST = (g == int'(itm_pkg::A_SW_MAX) && CFG_1XX) ?
        itm_pkg::SW_MAX_RST_1XX : itm_pkg::REG_RST[g];
      wire hit = reg_wr_i && (reg_addr_i == 4'(g));
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          cfg_q[g] <= RST;
        end else if (hit) begin
          cfg_q[g] <= wr_val;
        end
      end
    end
  endgenerate

  wire [15:0] mod_ref = cfg_q[itm_pkg::A_MOD_REF];
  wire [15:0] mod_ti = cfg_q[itm_pkg::A_MOD_TI];
  wire mod_sel = cfg_q[itm_pkg::A_MOD_SEL][0];
  wire signed [17:0] dev_lim = 18'(cfg_q[itm_pkg::A_DEV_LIM]);
  wire [15:0] imr_lo = cfg_q[itm_pkg::A_IMR_LO];
  wire [15:0] imr_rated = cfg_q[itm_pkg::A_IMR_RATED];
  wire [15:0] ref_flux = cfg_q[itm_pkg::A_REF_FLUX];
  wire [4:0] sw_max = cfg_q[itm_pkg::A_SW_MAX][4:0];
  wire [4:0] sw_min = cfg_q[itm_pkg::A_SW_MIN][4:0];
  wire signed [15:0] t_red = cfg_q[itm_pkg::A_T_RED];
  wire signed [15:0] t_off = cfg_q[itm_pkg::A_T_OFF];
  wire signed [15:0] fan_ton = cfg_q[itm_pkg::A_FAN_TON];
  wire [15:0] i_ol = cfg_q[itm_pkg::A_I_OL];
  wire icl_full = cfg_q[itm_pkg::A_CTRL][0];

  // Control sample divider.
  logic [31:0] smp_cnt_q;
  logic smp_tick_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      smp_cnt_q <= 32'h0;
      smp_tick_q <= 1'b0;
    end else begin
      smp_tick_q <= (smp_cnt_q == 32'(SAMPLE_CYC - 1));
      smp_cnt_q <= (smp_cnt_q == 32'(SAMPLE_CYC - 1)) ? 32'h0 : smp_cnt_q + 32'h1;
    end
  end

  // Modulation controller datapath.
  itm_pkg::itm_state_e st_q;
  logic div_start_q;
  logic [31:0] div_num_q;
  logic [15:0] div_den_q;
  logic div_done;
  logic [31:0] div_quo;
  logic [15:0] mod_q;
  logic err_neg_q;
  logic signed [31:0] step_q;
  logic signed [31:0] acc_q;

  itm_div u_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .start_i(div_start_q),
    .num_i(div_num_q),
    .den_i(div_den_q),
    .done_o(div_done),
    .quo_o(div_quo)
  );

  wire [15:0] mod_src = mod_sel ? meas_i.vabs : meas_i.usq;
  wire [31:0] mod_num = mod_src * itm_pkg::PCT_ONE;
  wire [15:0] quo_sat = (div_quo > 32'h0000FFFF) ? 16'hFFFF : div_quo[15:0];
  wire signed [17:0] err_raw = $signed({2'b00, mod_ref}) - $signed({2'b00, quo_sat});
  wire signed [17:0] err_c = (err_raw > dev_lim) ? dev_lim : (err_raw < -dev_lim) ? -dev_lim : err_raw;
  wire [17:0] err_abs = err_c[17] ? 18'(-err_c) : 18'(err_c);
  wire [31:0] flux_hi_w = (imr_rated * ref_flux) / 32'(itm_pkg::PCT_ONE);
  wire [15:0] flux_hi = (flux_hi_w > 32'h0000FFFF) ? 16'hFFFF : flux_hi_w[15:0];
  wire signed [31:0] lim_lo = $signed({8'h00, imr_lo, 8'h00});
  wire signed [31:0] lim_hi = $signed({8'h00, flux_hi, 8'h00});
  wire signed [31:0] acc_sum = acc_q + step_q;
  wire signed [31:0] quo_s = (div_quo > 32'h00FFFFFF) ? 32'sh00FFFFFF : $signed(div_quo);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= itm_pkg::ST_IDLE;
      div_start_q <= 1'b0;
      div_num_q <= 32'h0;
      div_den_q <= 16'h0;
      mod_q <= 16'h0;
      err_neg_q <= 1'b0;
      step_q <= 32'sh0;
      acc_q <= 32'sh00271000;
    end else begin
      div_start_q <= 1'b0;
      case (st_q)
        itm_pkg::ST_IDLE: begin
          if (smp_tick_q) begin
            div_num_q <= mod_num;
            div_den_q <= meas_i.udc;
            div_start_q <= 1'b1;
            st_q <= itm_pkg::ST_MOD;
          end
        end
        itm_pkg::ST_MOD: begin
          if (div_done) begin
            mod_q <= quo_sat;
            err_neg_q <= err_c[17];
            if (mod_ti == 16'h0) begin
              step_q <= 32'(err_c) <<< itm_pkg::FRAC;
              st_q <= itm_pkg::ST_UPD;
            end else begin
              div_num_q <= 32'(err_abs) * 32'h00000500;
              div_den_q <= 16'(mod_ti * 16'h0004);
              div_start_q <= 1'b1;
              st_q <= itm_pkg::ST_INT;
            end
          end
        end
        itm_pkg::ST_INT: begin
          if (div_done) begin
            step_q <= err_neg_q ? -quo_s : quo_s;
            st_q <= itm_pkg::ST_UPD;
          end
        end
        itm_pkg::ST_UPD: begin
          acc_q <= (acc_sum > lim_hi) ? lim_hi : (acc_sum < lim_lo) ? lim_lo : acc_sum;
          st_q <= itm_pkg::ST_IDLE;
        end
        default: begin
          st_q <= itm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Switching frequency adaptation, one step per step interval.
  logic [15:0] step_cnt_q;
  logic [4:0] sw_q;
  logic [4:0] sw_d;
  wire sw_tick = smp_tick_q && (step_cnt_q == 16'(itm_pkg::SW_STEP_SMP - 1));
  wire signed [15:0] t_lim = t_off + t_red;
  wire over_t = meas_i.t_hs > t_lim;
  wire cool_t = meas_i.t_hs < (t_lim - itm_pkg::T_HYST);
  wire [15:0] i_thr = i_ol - (i_ol >> 3);
  wire over_i = icl_full && (meas_i.iout > i_thr);
  wire [4:0] sw_up = sw_q + itm_pkg::SW_STEP_KHZ;
  wire [4:0] sw_dn = sw_q - itm_pkg::SW_STEP_KHZ;
  wire signed [31:0] i_ref_next = $signed({16'h0, i_thr}) -
    $signed({16'h0, i_ol >> 5}) * $signed({27'h0, sw_up - sw_min});
  wire under_i = !icl_full || ($signed({16'h0, meas_i.iout}) < i_ref_next);
  wire auto_off = sw_min >= sw_max;

  always_comb begin
    sw_d = sw_q;
    if (auto_off) begin
      sw_d = sw_max;
    end else if (sw_q > sw_max) begin
      sw_d = sw_max;
    end else if (sw_q < sw_min) begin
      sw_d = sw_min;
    end else if ((over_t || over_i) && sw_q > sw_min) begin
      sw_d = (sw_dn < sw_min) ? sw_min : sw_dn;
    end else if (cool_t && under_i && sw_q < sw_max) begin
      sw_d = (sw_up > sw_max) ? sw_max : sw_up;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      step_cnt_q <= 16'h0;
      sw_q <= CFG_1XX ? itm_pkg::SW_MAX_RST_1XX[4:0] : itm_pkg::REG_RST[itm_pkg::A_SW_MAX][4:0];
    end else if (smp_tick_q) begin
      step_cnt_q <= sw_tick ? 16'h0 : step_cnt_q + 16'h1;
      if (sw_tick) begin
        sw_q <= sw_d;
      end
    end
  end

  // Fan temperature hysteresis and fan outputs with minimum on-time.
  logic hot_q;
  logic [1:0] fan_q;
  logic [31:0] fan_tmr_q [2];
  wire run = ctrl_en && started;
  wire [1:0] fan_req = {run || hot_q, mains && (hot_q || run)};

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hot_q <= 1'b0;
    end else if (smp_tick_q) begin
      if (meas_i.t_hs > fan_ton) begin
        hot_q <= 1'b1;
      end else if (meas_i.t_hs < (fan_ton - itm_pkg::T_HYST)) begin
        hot_q <= 1'b0;
      end
    end
  end

  generate
    for (g = 0; g < 2; g++) begin : g_fan
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          fan_q[g] <= 1'b0;
          fan_tmr_q[g] <= 32'h0;
        end else if (smp_tick_q) begin
          if (!fan_q[g]) begin
            if (fan_req[g]) begin
              fan_q[g] <= 1'b1;
              fan_tmr_q[g] <= 32'(FAN_MIN_SMP - 1);
            end
          end else if (fan_tmr_q[g] != 32'h0) begin
            fan_tmr_q[g] <= fan_tmr_q[g] - 32'h1;
          end else if (!fan_req[g]) begin
            fan_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Output stage enable and output registers.
  logic pwm_en_q;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pwm_en_q <= 1'b0;
    end else begin
      pwm_en_q <= stage_en && ctrl_en;
    end
  end

  // Register read port, data valid in the cycle after the strobe only.
  logic [15:0] rdata_q;
  wire [15:0] status_w = {6'h00, mod_q[15:14] != 2'b00, pwm_en_q, fan_q, hot_q, sw_q};
  wire [15:0] rd_word = addr_ok ? cfg_q[idx] :
    (reg_addr_i == itm_pkg::A_STATUS) ? status_w : acc_q[23:8];
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0;
    end else begin
      rdata_q <= reg_rd_i ? rd_word : 16'h0;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign pwm_enable_o = pwm_en_q;
  assign flux_ref_o = acc_q[23:8];
  assign sw_freq_khz_o = sw_q;
  assign fan_int_o = fan_q[0];
  assign fan_ext_o = fan_q[1];
endmodule : itm_ctrl
`default_nettype wire

// ==== bench/itm_ctrl_sva.sv ====
// Port checker of the thermal and modulation controller.
`timescale 1ns/1ps
`default_nettype none
module itm_ctrl_chk #(
  parameter int SAMPLE_CYC = 50,
  parameter int FAN_MIN_SMP = 10
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic output_stage_enable_input_i,
  input wire logic mains_ok_i,
  input wire logic ctrl_enable_i,
  input wire logic start_cw_i,
  input wire logic start_ccw_i,
  input wire logic pwm_enable_o,
  input wire logic [15:0] flux_ref_o,
  input wire logic [4:0] sw_freq_khz_o,
  input wire logic fan_int_o,
  input wire logic fan_ext_o
);
  localparam int W = SAMPLE_CYC + 8;
  localparam int MIN_ON = (FAN_MIN_SMP - 1) * SAMPLE_CYC;
  logic run;
  logic [7:0] run_q;
  logic [31:0] on_q;
  assign run = ctrl_enable_i && (start_cw_i || start_ccw_i);
  always_ff @(posedge clk_sys_i) begin
    run_q <= {run_q[6:0], run};
    if (rst_i || !fan_int_o) begin
      on_q <= 32'h0000_0000;
    end else begin
      on_q <= on_q + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_stage_off;
    (!output_stage_enable_input_i) [*4] |-> !pwm_enable_o;
  endproperty
  a_stage_off: assert property (p_stage_off) else $error("stage on without enable");
  property p_stage_on;
    (output_stage_enable_input_i && ctrl_enable_i) [*4] |-> pwm_enable_o;
  endproperty
  a_stage_on: assert property (p_stage_on) else $error("stage not enabled");
  property p_sw_range;
    sw_freq_khz_o >= 5'h02 && sw_freq_khz_o <= 5'h10 && !sw_freq_khz_o[0];
  endproperty
  a_sw_range: assert property (p_sw_range) else $error("frequency out of range");
  property p_sw_step;
    sw_freq_khz_o != $past(sw_freq_khz_o) |->
      sw_freq_khz_o == $past(sw_freq_khz_o) + 5'h02 || sw_freq_khz_o + 5'h02 == $past(sw_freq_khz_o);
  endproperty
  a_sw_step: assert property (p_sw_step) else $error("frequency jumped");
  property p_flux_hold;
    flux_ref_o != $past(flux_ref_o) |=> $stable(flux_ref_o) [*8];
  endproperty
  a_flux_hold: assert property (p_flux_hold) else $error("flux changed between samples");
  property p_rd_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  property p_fan_min;
    $fell(fan_int_o) |-> on_q >= 32'(MIN_ON);
  endproperty
  a_fan_min: assert property (p_fan_min) else $error("fan off before minimum");
  property p_fan_run;
    (mains_ok_i && run) [*4] |-> ##[0:W] fan_int_o;
  endproperty
  a_fan_run: assert property (p_fan_run) else $error("fan not started by run");
  property p_ext_int;
    fan_int_o |-> fan_ext_o;
  endproperty
  a_ext_int: assert property (p_ext_int) else $error("external fan off");
  property p_fan_hold;
    $fell(fan_ext_o) |-> run_q != 8'hFF;
  endproperty
  a_fan_hold: assert property (p_fan_hold) else $error("external fan off while running");
endmodule : itm_ctrl_chk
bind itm_ctrl itm_ctrl_chk #(.SAMPLE_CYC(SAMPLE_CYC), .FAN_MIN_SMP(FAN_MIN_SMP)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .output_stage_enable_input_i(output_stage_enable_input_i), .mains_ok_i(mains_ok_i),
  .ctrl_enable_i(ctrl_enable_i), .start_cw_i(start_cw_i), .start_ccw_i(start_ccw_i),
  .pwm_enable_o(pwm_enable_o), .flux_ref_o(flux_ref_o), .sw_freq_khz_o(sw_freq_khz_o),
  .fan_int_o(fan_int_o), .fan_ext_o(fan_ext_o));
`default_nettype wire

// ==== bench/itm_plant.sv ====
// Behavioural model of the power stage sensors and stage enable pin.
`timescale 1ns/1ps
`default_nettype none
module itm_plant (
  input wire logic clk_sys_i,
  input wire itm_pkg::itm_meas_s set_i,
  input wire logic stage_on_i,
  output var itm_pkg::itm_meas_s meas_o,
  output logic stage_en_o
);
  // Sensor values settle one cycle after the operating point changes.
  always_ff @(posedge clk_sys_i) begin
    meas_o <= set_i;
    stage_en_o <= stage_on_i;
  end
endmodule : itm_plant
`default_nettype wire

// ==== bench/itm_ctrl_tb.sv ====
// Self-checking testbench of the thermal and modulation controller.
`timescale 1ns/1ps
`default_nettype none
module itm_ctrl_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic mains = 1'b0;
  logic en = 1'b0;
  logic cw = 1'b0;
  logic ccw = 1'b0;
  logic stage_on = 1'b0;
  itm_pkg::itm_meas_s set = '{16'h0000, 16'h0000, 16'h0FA0, 16'h0000, 16'sh00FA};
  itm_pkg::itm_meas_s meas;
  logic stage_en;
  logic [15:0] rdata;
  logic [15:0] flux;
  logic [4:0] sw;
  logic [4:0] sw_1xx;
  logic pwm;
  logic fan_i;
  logic fan_e;
  int n_fail = 0;
  int comparisons = 0;
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  itm_plant u_plant (.clk_sys_i(clk_sys_i), .set_i(set), .stage_on_i(stage_on), .meas_o(meas),
    .stage_en_o(stage_en));
  itm_ctrl #(.SAMPLE_CYC(50), .FAN_MIN_SMP(10)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .meas_i(meas), .output_stage_enable_input_i(stage_en), .mains_ok_i(mains), .ctrl_enable_i(en),
    .start_cw_i(cw), .start_ccw_i(ccw), .pwm_enable_o(pwm), .flux_ref_o(flux), .sw_freq_khz_o(sw),
    .fan_int_o(fan_i), .fan_ext_o(fan_e));
  // Second build variant whose maximum switching frequency starts at the lower default.
  itm_ctrl #(.SAMPLE_CYC(50), .FAN_MIN_SMP(10), .CFG_1XX(1'b1)) u_dut_1xx (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(),
    .meas_i(meas), .output_stage_enable_input_i(stage_en), .mains_ok_i(mains), .ctrl_enable_i(en),
    .start_cw_i(cw), .start_ccw_i(ccw), .pwm_enable_o(), .flux_ref_o(), .sw_freq_khz_o(sw_1xx),
    .fan_int_o(), .fan_ext_o());
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input string m);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    chk(rdata === e, m);
  endtask : rd_chk
  task automatic smp(input int n);
    repeat (n * 50) @(posedge clk_sys_i);
  endtask : smp
  task automatic t_regs;
    chk(sw_1xx === 5'h02, "lower default frequency variant");
    for (int i = 0; i < itm_pkg::NREG; i++) begin
      rd_chk(4'(i), itm_pkg::REG_RST[i], "reset value");
    end
    for (int i = 0; i < itm_pkg::NREG; i++) begin
      wr_reg(4'(i), 16'h8000);
      rd_chk(4'(i), itm_pkg::REG_MIN[i], "low clamp");
      wr_reg(4'(i), 16'h7FFF);
      rd_chk(4'(i), itm_pkg::REG_MAX[i], "high clamp");
      wr_reg(4'(i), itm_pkg::REG_RST[i]);
    end
  endtask : t_regs
  task automatic t_pwm;
    en <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    chk(pwm === 1'b0, "stage without enable pin");
    stage_on <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    chk(pwm === 1'b1, "stage enabled");
  endtask : t_pwm
  task automatic t_flux;
    wr_reg(itm_pkg::A_MOD_TI, 16'h0000);
    wr_reg(itm_pkg::A_DEV_LIM, 16'h000A);
    set.usq <= 16'h1388;
    smp(5);
    chk(flux <= 16'h2706 && flux >= 16'h26D4, "deviation clamp");
    wr_reg(itm_pkg::A_DEV_LIM, 16'h03E8);
    smp(30);
    chk(flux === 16'h0064, "lower flux clamp");
    wr_reg(itm_pkg::A_MOD_SEL, 16'h0001);
    set.vabs <= 16'h07D0;
    smp(30);
    chk(flux === 16'h2710, "upper flux clamp");
    wr_reg(itm_pkg::A_FLUX, 16'h0000);
    rd_chk(itm_pkg::A_FLUX, 16'h2710, "flux readback");
  endtask : t_flux
  task automatic t_fan;
    wr_reg(itm_pkg::A_FAN_TON, 16'h012C);
    set.t_hs <= 16'sh0064;
    smp(3);
    chk(fan_e === 1'b0, "cool external fan");
    mains <= 1'b1;
    set.t_hs <= 16'sh0190;
    smp(3);
    chk(fan_i === 1'b1 && fan_e === 1'b1, "hot fan on");
    set.t_hs <= 16'sh0064;
    smp(3);
    chk(fan_i === 1'b1, "minimum on-time");
    smp(12);
    chk(fan_i === 1'b0 && fan_e === 1'b0, "fan off after cooling");
    set.t_hs <= 16'sh0190;
    smp(14);
    set.t_hs <= 16'sh0113;
    smp(3);
    chk(fan_i === 1'b1, "fan hysteresis");
    set.t_hs <= 16'sh0064;
    smp(3);
    cw <= 1'b1;
    smp(2);
    chk(fan_i === 1'b1 && fan_e === 1'b1, "run fan on");
    mains <= 1'b0;
    cw <= 1'b0;
    ccw <= 1'b1;
    smp(14);
    chk(fan_i === 1'b0 && fan_e === 1'b1, "external fan on run");
    en <= 1'b0;
    smp(2);
    chk(fan_e === 1'b0, "fan off on disable");
  endtask : t_fan
  task automatic t_sw;
    chk(sw === 5'h04, "reset maximum frequency");
    set.t_hs <= 16'sh0320;
    smp(170);
    chk(sw === 5'h02, "thermal reduction");
    set.t_hs <= 16'sh02DA;
    smp(170);
    chk(sw === 5'h02, "no rise inside hysteresis");
    set.t_hs <= 16'sh02BC;
    smp(170);
    chk(sw === 5'h04, "stepwise recovery");
    wr_reg(itm_pkg::A_SW_MIN, 16'h0004);
    set.t_hs <= 16'sh0320;
    smp(170);
    chk(sw === 5'h04, "reduction disabled");
    wr_reg(itm_pkg::A_SW_MIN, 16'h0002);
    wr_reg(itm_pkg::A_CTRL, 16'h0001);
    set.t_hs <= 16'sh0064;
    set.iout <= 16'h0384;
    smp(170);
    chk(sw === 5'h02, "current reduction");
    set.iout <= 16'h0000;
    smp(170);
    chk(sw === 5'h04, "current recovery");
    rd_chk(itm_pkg::A_STATUS, 16'h0004, "status word");
  endtask : t_sw
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_regs();
    smp(10);
    t_pwm();
    t_flux();
    t_fan();
    t_sw();
    final_report();
  end
  initial begin
    repeat (95000) @(posedge clk_sys_i);
    n_fail++;
    final_report();
  end
endmodule : itm_ctrl_tb
`default_nettype wire
